// File: core/cache_pkg.sv
package cache_pkg;
  localparam int BUF_BYTES    = 64 * 1024 * 1024;
  localparam int CACHE_KBYTES = 30000;
  localparam int NSEG         = 4;
  localparam int SEG_W        = 2;
  localparam int SEG_BLKS     = 8;
  localparam int POS_W        = 3;
  localparam int CNT_W        = 4;
  localparam int LBA_W        = 32;
  localparam int LEN_W        = 8;
  localparam int DATA_W       = 32;
  localparam int FIFO_DEPTH   = 8;
  localparam int FIFO_CW      = 4;
  localparam int PF_BLKS      = 4;
  localparam int RATIO_W      = 8;
  localparam int STAMP_W      = 8;
  localparam int CNTR_W       = 16;
  localparam logic [15:0] SEG_SIZE_FIELD = 16'hffff;
  localparam logic [1:0]  PF_SCORE_RST   = 2'h2;
  localparam logic [1:0]  PF_SCORE_ON    = 2'h2;
  localparam logic [1:0]  PF_SCORE_MAX   = 2'h3;

  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_SYNC, OP_MODE_SEL, OP_MODE_SENSE
  } cmd_op_e;

  typedef enum logic [1:0] {ST_GOOD, ST_MEDIUM, ST_ILLEGAL} sts_code_e;

  typedef enum logic [2:0] {
    S_IDLE, S_LOOK, S_HIT, S_MISS, S_PF, S_WSET, S_WR
  } state_e;

  typedef struct packed {
    state_e                        st;
    logic [NSEG-1:0]               seg_valid;
    logic [NSEG-1:0]               seg_pf;
    logic [NSEG-1:0]               seg_dirty;
    logic [NSEG-1:0][LBA_W-1:0]    seg_base;
    logic [NSEG-1:0][LBA_W-1:0]    seg_lo;
    logic [NSEG-1:0][CNT_W-1:0]    seg_cnt;
    logic [NSEG-1:0][STAMP_W-1:0]  seg_stamp;
    logic [STAMP_W-1:0]            stamp;
    logic [SEG_W-1:0]              cur_seg;
    logic [LBA_W-1:0]              cur_lba;
    logic [LBA_W-1:0]              wr_lba;
    logic [LBA_W-1:0]              cm_lba;
    logic [LEN_W-1:0]              left;
    logic [LEN_W-1:0]              wr_left;
    logic [LEN_W-1:0]              cm_left;
    logic                          sts_sent;
    logic                          wr_err;
    logic                          push_done;
    logic                          med_req;
    logic                          med_we;
    logic [LBA_W-1:0]              med_lba;
    logic [DATA_W-1:0]             med_wdata;
    logic [1:0]                    pf_score;
    logic [CNTR_W-1:0]             cache_hits;
    logic [CNTR_W-1:0]             pf_hits;
    logic                          deferred_err;
    logic                          sts_valid;
    sts_code_e                     sts_code;
  } state_s;
endpackage

// File: core/fifo_if.sv
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 32, parameter int CW = 4) ();
  logic          in_valid;
  logic          in_ready;
  logic [W-1:0]  in_data;
  logic          out_valid;
  logic          out_ready;
  logic [W-1:0]  out_data;
  logic [CW-1:0] count;
  modport src  (output in_valid, in_data, out_ready,
                input  in_ready, out_valid, out_data, count);
  modport sink (input  in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data, count);
endinterface

// File: core/stream_fifo.sv
`timescale 1ns/1ps
module stream_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  fifo_if.sink      p
);
  import cache_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } fifo_s;

  fifo_s r;
  fifo_s r_nxt;
  logic  push;
  logic  pop;

  assign p.in_ready  = r.cnt != (AW+1)'(DEPTH);
  assign p.out_valid = r.cnt != '0;
  assign p.out_data  = r.mem[r.rp];
  assign p.count     = r.cnt;
  assign push        = p.in_valid && p.in_ready;
  assign pop         = p.out_valid && p.out_ready;

  always_comb
  begin
    r_nxt = r;
    if (push)
    begin
      r_nxt.mem[r.wp] = p.in_data;
      r_nxt.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + AW'(1);
    end
    if (pop)
      r_nxt.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + AW'(1);
    r_nxt.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else if (ce)
      r <= r_nxt;
  end

  no_overflow_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    p.in_valid |-> p.in_ready) else $error("push into full fifo");
endmodule

// File: core/seg_cache.sv
// What this block does
// - 64MB buffer, about 30,000 kbytes usable cache
// - Track held block addresses for every segment
// - Read caching on: look in buffer first
// - Read caching off: lookup only hits prefetched segments, else go medium
// - Host transfers paced by buffer-full ratio setting
// - Full hit: send cached blocks, no medium
// - Any miss: fetch blocks into segment, forward
// - Segments are block rings, created on demand
// - Segment-size readback always reads all ones
// - Unchangeable_param_check check rejects segment size change attempt
// - Written data kept cached when caching on and its commit did not fail
// - Segmentation independent of read-cache-disable setting
// - Write clears segments holding overlapping blocks
// - Write wraps, never overwrites uncommitted blocks
// - Write-back: early good status after caching
// - Commit failure after good raises deferred error
// - Synchronize completes only after all committed
// - Read-ahead buffers following blocks; prefetch hits
// - Host prefetch length and ceiling fields ignored
// - Prefetch toggled by predicted hit likelihood
// - Read-ahead and caching switched independently
`timescale 1ns/1ps
module seg_cache (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  input  wire logic                         cmd_valid,
  output logic                              cmd_ready,
  input  wire cache_pkg::cmd_op_e           cmd_op,
  input  wire logic [cache_pkg::LBA_W-1:0]  cmd_lba,
  input  wire logic [cache_pkg::LEN_W-1:0]  cmd_len,
  input  wire logic [15:0]                  cmd_seg_size,
  output logic                              sts_valid,
  output cache_pkg::sts_code_e              sts_code,
  input  wire logic                         wr_valid,
  output logic                              wr_ready,
  input  wire logic [cache_pkg::DATA_W-1:0] wr_data,
  output logic                              rd_valid,
  input  wire logic                         rd_ready,
  output logic [cache_pkg::DATA_W-1:0]      rd_data,
  output logic                              med_req,
  output logic                              med_we,
  output logic [cache_pkg::LBA_W-1:0]       med_lba,
  output logic [cache_pkg::DATA_W-1:0]      med_wdata,
  input  wire logic                         med_ack,
  input  wire logic [cache_pkg::DATA_W-1:0] med_rdata,
  input  wire logic                         med_err,
  input  wire logic                         read_cache_disable,
  input  wire logic                         write_back_enable,
  input  wire logic                         lookahead_disable,
  input  wire logic                         unchangeable_param_check,
  input  wire logic [cache_pkg::RATIO_W-1:0] full_ratio,
  output logic [15:0]                       seg_size_rb,
  output logic [cache_pkg::CNTR_W-1:0]      cache_hits,
  output logic [cache_pkg::CNTR_W-1:0]      prefetch_hits,
  output logic                              deferred_err,
  input  wire logic                         deferred_err_clr
);
  import cache_pkg::*;

  localparam int SEG_MAX = SEG_BLKS;

  // Only directory and one word per block are kept here; the bulk of the
  // BUF_BYTES / CACHE_KBYTES store sits in the external buffer RAM.
  logic [DATA_W-1:0]        blk_mem [NSEG*SEG_BLKS];
  state_s                   s;
  state_s                   n;
  logic                     mem_we;
  logic [SEG_W+POS_W-1:0]   mem_wa;
  logic [DATA_W-1:0]        mem_wd;
  logic [NSEG-1:0]          hit_v;
  logic [NSEG-1:0]          ov_v;
  logic [LBA_W:0]           lo_end;
  logic [LBA_W:0]           rq_end;
  logic [SEG_W-1:0]         victim;
  logic                     vfound;
  logic [STAMP_W-1:0]       best;
  logic [SEG_W-1:0]         pick;
  logic                     pick_ok;
  logic [LEN_W-1:0]         pend;
  logic                     defer_set;
  logic                     gate;
  logic [FIFO_CW-1:0]       thr;
  logic                     wr_take;

  fifo_if #(.W(DATA_W), .CW(FIFO_CW)) f ();

  stream_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .p     (f)
  );

  function automatic logic [SEG_W+POS_W-1:0] blk_idx(
    input logic [SEG_W-1:0] sg,
    input logic [LBA_W-1:0] lba,
    input logic [LBA_W-1:0] base
  );
    logic [LBA_W-1:0] d;
    d = lba - base;
    return {sg, d[POS_W-1:0]};
  endfunction

  // Ratio scaled to fifo depth; a zero ratio still needs one block
  assign thr = (full_ratio[RATIO_W-1 -: POS_W] == '0) ? FIFO_CW'(1) :
               {1'b0, full_ratio[RATIO_W-1 -: POS_W]};
  assign gate = (f.count >= thr) || s.push_done;
  assign rd_valid    = f.out_valid && gate;
  assign f.out_ready = rd_ready && gate && ce;
  assign rd_data     = f.out_data;
  assign cmd_ready   = ce && (s.st == S_IDLE);
  assign wr_ready    = ce && wr_take;
  assign seg_size_rb = SEG_SIZE_FIELD;
  assign sts_valid     = s.sts_valid;
  assign sts_code      = s.sts_code;
  assign med_req       = s.med_req;
  assign med_we        = s.med_we;
  assign med_lba       = s.med_lba;
  assign med_wdata     = s.med_wdata;
  assign cache_hits    = s.cache_hits;
  assign prefetch_hits = s.pf_hits;
  assign deferred_err  = s.deferred_err;
  assign pend = s.cm_left - s.wr_left;

  // Directory lookup, overlap test and victim choice
  always_comb
  begin
    hit_v = '0;
    ov_v = '0;
    lo_end = '0;
    rq_end = {1'b0, s.cur_lba} + (LBA_W+1)'(s.left);
    for (int i = 0; i < NSEG; i++)
    begin
      lo_end = {1'b0, s.seg_lo[i]} + (LBA_W+1)'(s.seg_cnt[i]);
      hit_v[i] = s.seg_valid[i] && (s.cur_lba >= s.seg_lo[i]) &&
                 (rq_end <= lo_end);
      ov_v[i] = s.seg_valid[i] && ({1'b0, s.cur_lba} < lo_end) &&
                ({1'b0, s.seg_lo[i]} < rq_end);
    end
    pick = '0;
    pick_ok = 1'b0;
    for (int i = 0; i < NSEG; i++)
    begin
      if (!pick_ok && hit_v[i] && (!read_cache_disable || s.seg_pf[i]))
      begin
        pick = SEG_W'(i);
        pick_ok = 1'b1;
      end
    end
    victim = '0;
    vfound = 1'b0;
    best = '1;
    for (int i = 0; i < NSEG; i++)
    begin
      if (!vfound && !s.seg_valid[i])
      begin
        victim = SEG_W'(i);
        vfound = 1'b1;
      end
    end
    // Stamps wrap, so age order is only approximate after 256 uses
    for (int i = 0; i < NSEG; i++)
    begin
      if (!vfound && !s.seg_dirty[i] && s.seg_stamp[i] < best)
      begin
        best = s.seg_stamp[i];
        victim = SEG_W'(i);
      end
    end
  end

  always_comb
  begin
    n = s;
    n.sts_valid = 1'b0;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    f.in_valid = 1'b0;
    f.in_data = '0;
    wr_take = 1'b0;
    defer_set = 1'b0;
    case (s.st)
      S_IDLE:
      begin
        if (cmd_valid)
        begin
          n.cur_lba = cmd_lba;
          n.left = cmd_len;
          case (cmd_op)
            OP_READ:
            begin
              n.push_done = 1'b0;
              n.st = S_LOOK;
            end
            OP_WRITE:
              n.st = S_WSET;
            OP_MODE_SEL:
            begin
              // Segment size from the host never changes segmentation
              n.sts_valid = 1'b1;
              n.sts_code = (unchangeable_param_check &&
                            cmd_seg_size != SEG_SIZE_FIELD) ?
                           ST_ILLEGAL : ST_GOOD;
            end
            default:
            begin
              // Idle always means every segment is committed
              n.sts_valid = 1'b1;
              n.sts_code = ST_GOOD;
            end
          endcase
        end
      end
      S_LOOK:
      begin
        n.stamp = s.stamp + 8'h1;
        if (pick_ok)
        begin
          n.cur_seg = pick;
          n.seg_stamp[pick] = s.stamp;
          if (s.seg_pf[pick])
          begin
            n.pf_hits = s.pf_hits + 16'h1;
            if (s.pf_score != PF_SCORE_MAX)
              n.pf_score = s.pf_score + 2'h1;
          end
          else
            n.cache_hits = s.cache_hits + 16'h1;
          n.st = S_HIT;
        end
        else
        begin
          n.cur_seg = victim;
          n.seg_valid[victim] = 1'b1;
          n.seg_pf[victim] = 1'b0;
          n.seg_base[victim] = s.cur_lba;
          n.seg_lo[victim] = s.cur_lba;
          n.seg_cnt[victim] = '0;
          n.seg_stamp[victim] = s.stamp;
          // Cold misses leave the predictor alone, else it never climbs
          if (s.pf_score != '0 && (s.seg_pf & s.seg_valid) != '0)
            n.pf_score = s.pf_score - 2'h1;
          n.st = S_MISS;
        end
      end
      S_HIT:
      begin
        if (s.left == '0)
        begin
          n.push_done = 1'b1;
          n.sts_valid = 1'b1;
          n.sts_code = ST_GOOD;
          n.st = S_IDLE;
        end
        else if (f.in_ready)
        begin
          f.in_valid = 1'b1;
          f.in_data = blk_mem[blk_idx(s.cur_seg, s.cur_lba,
                                      s.seg_base[s.cur_seg])];
          n.cur_lba = s.cur_lba + 32'h1;
          n.left = s.left - 8'h1;
        end
      end
      S_MISS, S_PF:
      begin
        if (s.med_req && med_ack)
        begin
          n.med_req = 1'b0;
          if (med_err)
          begin
            // A failed prefetch is dropped; blocks already read stay
            if (s.st == S_MISS)
            begin
              n.sts_valid = 1'b1;
              n.sts_code = ST_MEDIUM;
              n.push_done = 1'b1;
              n.seg_valid[s.cur_seg] = 1'b0;
            end
            n.st = S_IDLE;
          end
          else
          begin
            mem_we = 1'b1;
            mem_wa = blk_idx(s.cur_seg, s.cur_lba, s.seg_base[s.cur_seg]);
            mem_wd = med_rdata;
            if (s.seg_cnt[s.cur_seg] < CNT_W'(SEG_MAX))
              n.seg_cnt[s.cur_seg] = s.seg_cnt[s.cur_seg] + 4'h1;
            else
              n.seg_lo[s.cur_seg] = s.seg_lo[s.cur_seg] + 32'h1;
            if (s.st == S_MISS)
            begin
              f.in_valid = 1'b1;
              f.in_data = med_rdata;
            end
            n.cur_lba = s.cur_lba + 32'h1;
            n.left = s.left - 8'h1;
          end
        end
        else if (!s.med_req && s.left != '0 &&
                 (s.st == S_PF || f.in_ready))
        begin
          n.med_req = 1'b1;
          n.med_we = 1'b0;
          n.med_lba = s.cur_lba;
        end
        else if (!s.med_req && s.left == '0)
        begin
          n.st = S_IDLE;
          if (s.st == S_MISS)
          begin
            n.push_done = 1'b1;
            n.sts_valid = 1'b1;
            n.sts_code = ST_GOOD;
            // Fixed read-ahead length; host prefetch limits not used
            if (!lookahead_disable && s.pf_score >= PF_SCORE_ON)
            begin
              n.left = LEN_W'(PF_BLKS);
              n.seg_pf[s.cur_seg] = 1'b1;
              n.st = S_PF;
            end
          end
        end
      end
      S_WSET:
      begin
        for (int i = 0; i < NSEG; i++)
        begin
          if (ov_v[i])
            n.seg_valid[i] = 1'b0;
        end
        // Same allocation path as reads, whatever read caching says
        n.cur_seg = victim;
        n.seg_valid[victim] = 1'b0;
        n.seg_dirty[victim] = 1'b1;
        n.seg_pf[victim] = 1'b0;
        n.seg_base[victim] = s.cur_lba;
        n.seg_lo[victim] = s.cur_lba;
        n.seg_cnt[victim] = '0;
        n.seg_stamp[victim] = s.stamp;
        n.stamp = s.stamp + 8'h1;
        n.wr_lba = s.cur_lba;
        n.cm_lba = s.cur_lba;
        n.wr_left = s.left;
        n.cm_left = s.left;
        n.sts_sent = 1'b0;
        n.wr_err = 1'b0;
        n.st = S_WR;
      end
      S_WR:
      begin
        wr_take = (s.wr_left != '0) && (pend < LEN_W'(SEG_MAX));
        if (wr_valid && ce && wr_take)
        begin
          mem_we = 1'b1;
          mem_wa = blk_idx(s.cur_seg, s.wr_lba, s.seg_base[s.cur_seg]);
          mem_wd = wr_data;
          if (s.seg_cnt[s.cur_seg] < CNT_W'(SEG_MAX))
            n.seg_cnt[s.cur_seg] = s.seg_cnt[s.cur_seg] + 4'h1;
          else
            n.seg_lo[s.cur_seg] = s.seg_lo[s.cur_seg] + 32'h1;
          n.wr_lba = s.wr_lba + 32'h1;
          n.wr_left = s.wr_left - 8'h1;
        end
        if (s.med_req && med_ack)
        begin
          n.med_req = 1'b0;
          n.cm_lba = s.cm_lba + 32'h1;
          n.cm_left = s.cm_left - 8'h1;
          if (med_err)
            n.wr_err = 1'b1;
        end
        else if (!s.med_req && pend != '0)
        begin
          n.med_req = 1'b1;
          n.med_we = 1'b1;
          n.med_lba = s.cm_lba;
          n.med_wdata = blk_mem[blk_idx(s.cur_seg, s.cm_lba,
                                        s.seg_base[s.cur_seg])];
        end
        if (write_back_enable && s.wr_left == '0 && !s.sts_sent)
        begin
          n.sts_valid = 1'b1;
          n.sts_code = ST_GOOD;
          n.sts_sent = 1'b1;
        end
        if (s.wr_left == '0 && s.cm_left == '0)
        begin
          n.seg_dirty[s.cur_seg] = 1'b0;
          n.seg_valid[s.cur_seg] = !read_cache_disable && !s.wr_err;
          if (!s.sts_sent)
          begin
            n.sts_valid = 1'b1;
            n.sts_code = s.wr_err ? ST_MEDIUM : ST_GOOD;
          end
          else if (s.wr_err)
            defer_set = 1'b1;
          n.st = S_IDLE;
        end
      end
      default:
        n.st = S_IDLE;
    endcase
    // A new failure wins over a clear in the same cycle
    n.deferred_err = defer_set || (s.deferred_err && !deferred_err_clr);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.pf_score <= PF_SCORE_RST;
    end
    else if (ce)
      s <= n;
  end

  always_ff @(posedge clk)
  begin
    if (ce && mem_we)
      blk_mem[mem_wa] <= mem_wd;
  end

  sequence wr_all_taken;
    s.st == S_WR && s.wr_left == '0 && !s.sts_sent && write_back_enable;
  endsequence

  sequence unchangeable_param_check_req;
    s.st == S_IDLE && cmd_valid && cmd_op == OP_MODE_SEL &&
    unchangeable_param_check && cmd_seg_size != SEG_SIZE_FIELD;
  endsequence

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);

  seg_field_a: assert property (seg_size_rb == 16'hffff)
    else $error("segment size readback not all ones");
  unchangeable_param_check_rej_a: assert property (unchangeable_param_check_req |=> sts_valid &&
    sts_code == ST_ILLEGAL) else $error("segment size change not refused");
  rcd_skip_a: assert property (s.st == S_LOOK && read_cache_disable &&
    (hit_v & s.seg_pf) == '0 |=> s.st == S_MISS)
    else $error("lookup used with read caching off");
  hit_nomed_a: assert property (s.st == S_HIT |-> !med_req)
    else $error("medium touched on full hit");
  miss_fetch_a: assert property (s.st == S_MISS && !med_req &&
    s.left != '0 && f.in_ready |=> med_req && !med_we)
    else $error("miss did not fetch from medium");
  no_overrun_a: assert property (s.st == S_WR |->
    pend <= LEN_W'(SEG_MAX)) else $error("uncommitted block overwritten");
  clear_ovl_a: assert property (s.st == S_WSET |=>
    (ov_v & s.seg_valid) == '0) else $error("overlapping segment kept");
  early_good_a: assert property (wr_all_taken |=> sts_valid &&
    sts_code == ST_GOOD) else $error("no early good status");
  defer_a: assert property ($rose(deferred_err) |->
    $past(s.sts_sent) && $past(s.wr_err))
    else $error("deferred error without early good");
  sync_clean_a: assert property (s.st == S_IDLE && cmd_valid &&
    cmd_op == OP_SYNC |-> s.seg_dirty == '0 ##1 sts_valid)
    else $error("sync completed with dirty data");
  pace_a: assert property (!s.push_done && f.count <
    FIFO_CW'(full_ratio[RATIO_W-1 -: POS_W]) |-> !rd_valid)
    else $error("host transfer ahead of full ratio");
  pf_start_a: assert property (s.st == S_MISS && !med_req &&
    s.left == '0 && (lookahead_disable || s.pf_score < PF_SCORE_ON)
    |=> s.st == S_IDLE) else $error("prefetch started when unlikely");
endmodule

// File: test/medium_model.sv
`timescale 1ns/1ps
module medium_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        med_req,
  input  wire logic [31:0] med_lba,
  input  wire logic [1:0]  dly,
  input  wire logic [31:0] err_lba,
  output logic             med_ack,
  output logic [31:0]      med_rdata,
  output logic             med_err,
  output logic [7:0]       req_count
);
  logic [1:0] cnt_r;
  // Data bus toggles outside an ack so stale words never look valid
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      med_ack   <= 1'b0;
      med_err   <= 1'b0;
      med_rdata <= 32'h0;
      cnt_r     <= 2'h0;
      req_count <= 8'h0;
    end
    else if (med_ack || !med_req)
    begin
      med_ack   <= 1'b0;
      med_err   <= 1'b0;
      med_rdata <= ~med_rdata;
      cnt_r     <= 2'h0;
    end
    else if (cnt_r == dly)
    begin
      med_ack   <= 1'b1;
      med_rdata <= ~med_lba;
      med_err   <= (med_lba == err_lba);
      req_count <= req_count + 8'h1;
    end
    else
    begin
      cnt_r     <= cnt_r + 2'h1;
      med_rdata <= ~med_rdata;
    end
endmodule

// File: test/seg_cache_test.sv
`timescale 1ns/1ps
module seg_cache_test;
  import cache_pkg::*;
  typedef struct packed {
    cmd_op_e     op;
    logic [31:0] lba;
    logic [7:0]  len;
    sts_code_e   code;
    logic [15:0] hits;
    logic [7:0]  reqs;
  } row_s;
  logic clk, rst_n, ce, cmd_valid, cmd_ready, sts_valid, wr_valid, wr_ready;
  logic rd_valid, rd_ready, med_req, med_we, med_ack, med_err, deferred_err;
  logic read_cache_disable, write_back_enable, lookahead_disable;
  logic unchangeable_param_check, deferred_err_clr;
  logic wr_hs;
  cmd_op_e     cmd_op;
  sts_code_e   sts_code;
  logic [31:0] cmd_lba, wr_data, rd_data, med_lba, med_wdata, med_rdata;
  logic [31:0] err_lba, w0, mw;
  logic [15:0] cmd_seg_size, seg_size_rb, cache_hits, prefetch_hits;
  logic [7:0]  cmd_len, full_ratio, req_count, r0;
  logic [1:0]  dly;
  logic [31:0] q[$];
  int          err_count, check_count;
  row_s rows[6] = '{
    '{OP_READ, 32'h10, 8'h2, ST_GOOD, 16'h0, 8'h2},
    '{OP_READ, 32'h10, 8'h2, ST_GOOD, 16'h1, 8'h2},
    '{OP_READ, 32'h11, 8'h1, ST_GOOD, 16'h2, 8'h2},
    '{OP_READ, 32'h11, 8'h2, ST_GOOD, 16'h2, 8'h4},
    '{OP_MODE_SENSE, 32'h0, 8'h0, ST_GOOD, 16'h2, 8'h4},
    '{OP_SYNC, 32'h0, 8'h0, ST_GOOD, 16'h2, 8'h4}};

  seg_cache seg_cache_inst (.clk, .rst_n, .ce, .cmd_valid, .cmd_ready,
    .cmd_op, .cmd_lba, .cmd_len, .cmd_seg_size, .sts_valid, .sts_code,
    .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready, .rd_data, .med_req,
    .med_we, .med_lba, .med_wdata, .med_ack, .med_rdata, .med_err,
    .read_cache_disable, .write_back_enable, .lookahead_disable,
    .unchangeable_param_check, .full_ratio, .seg_size_rb, .cache_hits,
    .prefetch_hits, .deferred_err, .deferred_err_clr);
  medium_model medium_model_inst (.clk, .rst_n, .med_req, .med_lba, .dly,
    .err_lba, .med_ack, .med_rdata, .med_err, .req_count);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (rd_valid && rd_ready)
      q.push_back(rd_data);
    if (med_req && med_ack && med_we)
      mw <= med_wdata;
    wr_hs <= wr_valid && wr_ready;
  end

  // Next write word goes out on the falling edge after a take
  always @(negedge clk)
  begin
    if (wr_hs)
      wr_data = wr_data + 32'h1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic reset_dut();
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
  endtask

  // Status waits are bounded; a stuck command falls through to a failing compare
  task automatic run(input cmd_op_e op, input logic [31:0] lba,
                     input logic [7:0] len, input logic [15:0] sz);
    int n;
    q.delete();
    cmd_op = op;
    cmd_lba = lba;
    cmd_len = len;
    cmd_seg_size = sz;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (sts_valid !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    while ((cmd_ready !== 1'b1 ||
            (op == OP_READ && sts_code === ST_GOOD && q.size() < len))
           && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, n < 3000}, 32'h1);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test();
  end

  initial
  begin
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_SYNC;
    cmd_lba = 32'h0;
    cmd_len = 8'h0;
    cmd_seg_size = 16'hffff;
    wr_valid = 1'b1;
    wr_data = 32'h100;
    rd_ready = 1'b1;
    read_cache_disable = 1'b0;
    write_back_enable = 1'b0;
    lookahead_disable = 1'b1;
    unchangeable_param_check = 1'b0;
    deferred_err_clr = 1'b0;
    full_ratio = 8'h20;
    dly = 2'h0;
    err_lba = 32'hffff;
    reset_dut();
    chk({16'h0, seg_size_rb}, 32'hffff);
    chk({16'h0, cache_hits}, 32'h0);
    foreach (rows[i])
    begin
      run(rows[i].op, rows[i].lba, rows[i].len, 16'hffff);
      chk({30'h0, sts_code}, {30'h0, rows[i].code});
      chk({16'h0, cache_hits}, {16'h0, rows[i].hits});
      chk({24'h0, req_count}, {24'h0, rows[i].reqs});
      for (int j = 0; j < rows[i].len; j++)
        chk(q[j], ~(rows[i].lba + j));
    end
    unchangeable_param_check = 1'b1;
    run(OP_MODE_SEL, 32'h0, 8'h0, 16'h0200);
    chk({30'h0, sts_code}, {30'h0, ST_ILLEGAL});
    run(OP_MODE_SEL, 32'h0, 8'h0, 16'hffff);
    chk({30'h0, sts_code}, {30'h0, ST_GOOD});
    unchangeable_param_check = 1'b0;
    run(OP_MODE_SEL, 32'h0, 8'h0, 16'h0200);
    chk({30'h0, sts_code}, {30'h0, ST_GOOD});
    read_cache_disable = 1'b1;
    r0 = req_count;
    run(OP_READ, 32'h10, 8'h2, 16'hffff);
    chk({24'h0, req_count - r0}, 32'h2);
    read_cache_disable = 1'b0;
    w0 = wr_data;
    run(OP_WRITE, 32'h10, 8'h2, 16'hffff);
    chk(mw, w0 + 32'h1);
    run(OP_READ, 32'h10, 8'h2, 16'hffff);
    chk(q[0], w0);
    chk(q[1], w0 + 32'h1);
    chk({24'h0, req_count - r0}, 32'h4);
    write_back_enable = 1'b1;
    err_lba = 32'h28;
    run(OP_WRITE, 32'h28, 8'h2, 16'hffff);
    chk({30'h0, sts_code}, {30'h0, ST_GOOD});
    chk({31'h0, deferred_err}, 32'h1);
    run(OP_SYNC, 32'h0, 8'h0, 16'hffff);
    chk({30'h0, sts_code}, {30'h0, ST_GOOD});
    deferred_err_clr = 1'b1;
    @(negedge clk);
    deferred_err_clr = 1'b0;
    chk({31'h0, deferred_err}, 32'h0);
    dly = 2'h3;
    err_lba = 32'h3c;
    run(OP_READ, 32'h3c, 8'h1, 16'hffff);
    chk({30'h0, sts_code}, {30'h0, ST_MEDIUM});
    // Fresh reset so earlier misses do not bias the hit predictor
    reset_dut();
    dly = 2'h1;
    lookahead_disable = 1'b0;
    read_cache_disable = 1'b1;
    run(OP_READ, 32'h64, 8'h1, 16'hffff);
    chk({24'h0, req_count}, 32'h5);
    run(OP_READ, 32'h65, 8'h2, 16'hffff);
    chk(q[1], ~32'h66);
    chk({16'h0, prefetch_hits}, 32'h1);
    chk({16'h0, cache_hits}, 32'h0);
    chk({24'h0, req_count}, 32'h5);
    finish_test();
  end
endmodule
